/* File: core/gsf_regs.sv */
`timescale 1ns/1ps
module gsf_regs
    import gsf_pkg::*;
#(
    parameter int unsigned TEMP_FAST_CYC = TEMP_FAST_CYCLES,
    parameter int unsigned TEMP_SLOW_CYC = TEMP_SLOW_CYCLES,
    parameter int unsigned ODR_REF_CYC   = ODR_REF_CYCLES
)(
    input  wire logic                   sys_clk_i,
    input  wire logic                   srst_i,
    input  wire logic                   spi_sck_i,
    input  wire logic                   spi_csn_i,
    input  wire logic                   spi_mosi_i,
    output logic                        spi_miso_o,
    output logic                        spi_miso_oe_n_o,
    input  wire logic [1:0]             gyr_pmu_state_i,
    input  wire logic                   thermal_power_state_i,
    output logic                        temp_meas_req_o,
    input  wire logic                   temp_done_i,
    input  wire logic [15:0]            temp_raw_i,
    input  wire logic                   fwm_event_i,
    input  wire logic                   ffull_event_i,
    input  wire logic                   drdy_event_i,
    input  wire logic                   frame_written_i,
    input  wire logic [FRAME_LEN_W-1:0] frame_wr_len_i,
    input  wire logic                   fifo_reset_i,
    input  wire logic [FRAME_LEN_W-1:0] frame_rd_len_i,
    input  wire logic                   fifo_last_frame_i,
    input  wire logic [7:0]             fifo_rd_byte_i,
    output logic [FRAME_LEN_W-1:0]      fifo_rd_offset_o,
    output logic                        frame_pop_o,
    output logic [3:0]                  odr_code_o,
    output logic [1:0]                  bw_code_o,
    output logic                        sample_tick_o,
    output logic                        conf_error_o,
    output logic [7:0]                  err_code_o
);

    // ------------------------------------------------------------------
    // Serial port sampling
    // ------------------------------------------------------------------
    logic [2:0]             pins_s;
    logic                   csn_s;
    logic                   sck_s;
    logic                   mosi_s;
    logic                   sck_prev_q;
    logic                   csn_prev_q;

    // Chip select resets high so a reset never looks like a frame start.
    gsf_sync #(
        .W         (3),
        .RESET_VAL (3'h4)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .async_i   ({spi_csn_i, spi_sck_i, spi_mosi_i}),
        .sync_o    (pins_s)
    );

    assign csn_s  = pins_s[2];
    assign sck_s  = pins_s[1];
    assign mosi_s = pins_s[0];

    // Edge history is taken from the second synchroniser stage only.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sck_prev_q <= 1'b0;
            csn_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            csn_prev_q <= csn_s;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_end;

    // The host clock only counts while the device is selected.
    assign sck_rise = ~csn_s & sck_s & ~sck_prev_q;
    assign sck_fall = ~csn_s & ~sck_s & sck_prev_q;
    assign cs_end   = csn_s & ~csn_prev_q;

    // ------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------
    gsf_spi_e   state_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] rx_q;
    logic       rw_q;
    logic [6:0] addr_q;
    logic       load_q;
    logic [7:0] tx_q;
    logic [7:0] sh_q;
    logic       miso_q;
    logic       oe_n_q;
    logic [7:0] rd_mux;

    logic       byte_done;
    logic [7:0] rx_byte;
    logic       data_done;
    logic       wr_stb;
    logic       readout_adv;
    logic       at_readout;

    assign byte_done   = sck_rise & (bit_cnt_q == 3'h7);
    assign rx_byte     = {rx_q, mosi_s};
    assign data_done   = byte_done & (state_q == SP_DATA);
    assign wr_stb      = data_done & ~rw_q;
    assign at_readout  = (addr_q == ADDR_READOUT);
    assign readout_adv = data_done & rw_q & at_readout;

    // Bits are taken on rising host clock edges, most significant first.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || cs_end) begin
            bit_cnt_q <= 3'h0;
            rx_q      <= 7'h00;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_q      <= rx_byte[6:0];
        end
    end

    // First byte carries direction and address, then data follows.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || cs_end) begin
            state_q <= SP_CMD;
            rw_q    <= 1'b0;
            addr_q  <= 7'h00;
        end else if (byte_done) begin
            case (state_q)
                SP_CMD: begin
                    state_q <= SP_DATA;
                    rw_q    <= rx_byte[CMD_RW_BIT];
                    addr_q  <= rx_byte[6:0];
                end
                SP_DATA: begin
                    if (!at_readout) begin
                        addr_q <= addr_q + 7'h01;
                    end
                end
                default: begin
                    state_q <= SP_CMD;
                end
            endcase
        end
    end

    // The read byte is fetched one cycle after the byte boundary so the
    // readout offset has already moved; the next falling edge is far later.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            load_q <= 1'b0;
            tx_q   <= 8'h00;
        end else begin
            load_q <= byte_done & ((state_q == SP_CMD) ? rx_byte[CMD_RW_BIT] : rw_q);
            if (load_q) begin
                tx_q <= rd_mux;
            end
        end
    end

    // Output bits change on falling host clock edges.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            miso_q <= 1'b0;
            sh_q   <= 8'h00;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= csn_s;
            if (sck_fall && (state_q == SP_DATA) && rw_q) begin
                if (bit_cnt_q == 3'h0) begin
                    miso_q <= tx_q[7];
                    sh_q   <= {tx_q[6:0], 1'b0};
                end else begin
                    miso_q <= sh_q[7];
                    sh_q   <= {sh_q[6:0], 1'b0};
                end
            end
        end
    end

    assign spi_miso_o      = miso_q;
    assign spi_miso_oe_n_o = oe_n_q;

    // ------------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------------
    logic [2:0] flags_q;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;

    // Engines are gated by their enables upstream, so every event counts.
    assign flag_set = {fwm_event_i, ffull_event_i, drdy_event_i};
    assign flag_clr = wr_stb && (addr_q == ADDR_INT_FLAGS) ?
                      {rx_byte[FLAG_FWM_BIT], rx_byte[FLAG_FFULL_BIT], rx_byte[FLAG_DRDY_BIT]} : 3'h0;

    // Writing one clears a flag; an event in the same cycle wins.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            flags_q <= 3'h0;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    // ------------------------------------------------------------------
    // Temperature
    // ------------------------------------------------------------------
    gsf_temp_e   temp_mode;
    logic [31:0] fast_cnt_q;
    logic [31:0] slow_cnt_q;
    logic [15:0] temp_q;
    logic        req_q;
    logic        fast_tick;
    logic        slow_tick;

    // Mode follows the rate sensor and thermal unit power states.
    always_comb begin
        case (gyr_pmu_state_i)
            PMU_NORMAL:     temp_mode = TM_FAST;
            PMU_SUSPEND:    temp_mode = (thermal_power_state_i == THERMAL_NORMAL) ? TM_SLOW : TM_OFF;
            PMU_FAST_START: temp_mode = TM_SLOW;
            default:        temp_mode = TM_OFF;
        endcase
    end

    assign fast_tick = (fast_cnt_q == TEMP_FAST_CYC - 1);
    assign slow_tick = (slow_cnt_q == TEMP_SLOW_CYC - 1);

    // The slow grid runs free so slow updates stay on a fixed 1.28 s beat
    // instead of drifting with each power state change.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || slow_tick) begin
            slow_cnt_q <= 32'h0000_0000;
        end else begin
            slow_cnt_q <= slow_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || fast_tick || (temp_mode != TM_FAST)) begin
            fast_cnt_q <= 32'h0000_0000;
        end else begin
            fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
        end
    end

    // Measurement requests and result capture; no measuring when off.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            req_q  <= 1'b0;
            temp_q <= TEMP_RESET;
        end else begin
            req_q <= (temp_mode == TM_FAST && fast_tick) || (temp_mode == TM_SLOW && slow_tick);
            if (temp_mode == TM_OFF) begin
                temp_q <= TEMP_INVALID;
            end else if (temp_done_i) begin
                temp_q <= temp_raw_i;
            end
        end
    end

    assign temp_meas_req_o = req_q;

    // ------------------------------------------------------------------
    // Queue readout and fill count
    // ------------------------------------------------------------------
    logic [FILL_W-1:0]      fill_q;
    logic [FILL_W:0]        fill_sum;
    logic [FILL_W-1:0]      fill_d;
    logic [FRAME_LEN_W-1:0] offset_q;
    logic                   pop_q;
    logic                   queue_empty;
    logic                   frame_end;

    assign queue_empty = (fill_q == FILL_RESET);
    assign frame_end   = readout_adv && !queue_empty &&
                         (offset_q + 1'b1 >= frame_rd_len_i);

    // Count moves by whole frames only and saturates at all ones instead of wrapping.
    assign fill_sum = {1'b0, fill_q}
                    + (frame_written_i ? {{(FILL_W+1-FRAME_LEN_W){1'b0}}, frame_wr_len_i} : '0)
                    - (frame_end ? {{(FILL_W+1-FRAME_LEN_W){1'b0}}, frame_rd_len_i} : '0);
    assign fill_d   = fill_sum[FILL_W] ? {FILL_W{1'b1}} : fill_sum[FILL_W-1:0];

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || fifo_reset_i || (frame_end && fifo_last_frame_i)) begin
            fill_q <= FILL_RESET;
        end else begin
            fill_q <= fill_d;
        end
    end

    // Ending a burst mid-frame rewinds to the frame start for a resend.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || cs_end || fifo_reset_i) begin
            offset_q <= '0;
            pop_q    <= 1'b0;
        end else begin
            pop_q <= frame_end;
            if (frame_end) begin
                offset_q <= '0;
            end else if (readout_adv && !queue_empty) begin
                offset_q <= offset_q + 1'b1;
            end
        end
    end

    assign fifo_rd_offset_o = offset_q;
    assign frame_pop_o      = pop_q;

    // ------------------------------------------------------------------
    // Rate and bandwidth setup
    // ------------------------------------------------------------------
    logic [5:0]  setup_q;
    logic [3:0]  applied_odr_q;
    logic [31:0] odr_cnt_q;
    logic [31:0] odr_period;
    logic        tick_q;
    logic        err_q;
    logic [3:0]  odr_field;
    logic [1:0]  bwp_field;
    logic        setup_illegal;

    assign odr_field     = setup_q[ODR_LSB +: 4];
    assign bwp_field     = setup_q[BWP_LSB +: 2];
    assign setup_illegal = (odr_field < ODR_MIN_LEGAL) || (odr_field > ODR_MAX_LEGAL) ||
                           (bwp_field == BWP_UNDEFINED);

    // Only the six defined bits are stored.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            setup_q <= RATE_SETUP_RESET[5:0];
        end else if (wr_stb && (addr_q == ADDR_RATE_SETUP)) begin
            setup_q <= rx_byte[5:0];
        end
    end

    // An illegal setting keeps the last legal rate running and is flagged.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            applied_odr_q <= RATE_SETUP_RESET[3:0];
            err_q         <= 1'b0;
        end else begin
            err_q <= setup_illegal;
            if (!setup_illegal) begin
                applied_odr_q <= odr_field;
            end
        end
    end

    // Period is four reference periods at 25 Hz, halved per code step.
    assign odr_period = (ODR_REF_CYC * 4) >> (applied_odr_q - ODR_MIN_LEGAL);

    // The rate generator ignores the power state entirely.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            odr_cnt_q <= 32'h0000_0000;
            tick_q    <= 1'b0;
        end else begin
            tick_q <= (odr_cnt_q >= odr_period - 1);
            if (odr_cnt_q >= odr_period - 1) begin
                odr_cnt_q <= 32'h0000_0000;
            end else begin
                odr_cnt_q <= odr_cnt_q + 32'h0000_0001;
            end
        end
    end

    assign odr_code_o    = applied_odr_q;
    assign bw_code_o     = bwp_field;
    assign sample_tick_o = tick_q;
    assign conf_error_o  = err_q;
    assign err_code_o    = err_q ? ERR_CODE_CONF : ERR_CODE_NONE;

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    logic [7:0] flags_byte;

    assign flags_byte = ({7'h00, flags_q[2]} << FLAG_FWM_BIT)
                      | ({7'h00, flags_q[1]} << FLAG_FFULL_BIT)
                      | ({7'h00, flags_q[0]} << FLAG_DRDY_BIT);

    // Unmapped addresses read zero; an empty queue returns a fixed byte.
    always_comb begin
        case (addr_q)
            ADDR_INT_FLAGS:  rd_mux = flags_byte;
            ADDR_TEMP_LO:    rd_mux = temp_q[7:0];
            ADDR_TEMP_HI:    rd_mux = temp_q[15:8];
            ADDR_FILL_LO:    rd_mux = fill_q[7:0];
            ADDR_FILL_HI:    rd_mux = {5'h00, fill_q[FILL_W-1:8]};
            ADDR_READOUT:    rd_mux = queue_empty ? READOUT_EMPTY : fifo_rd_byte_i;
            ADDR_RATE_SETUP: rd_mux = {2'h0, setup_q};
            default:         rd_mux = UNMAPPED_READ;
        endcase
    end

endmodule

/* File: shared/gsf_pkg.sv */
package gsf_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W           = 7;
    localparam logic [6:0]  ADDR_INT_FLAGS   = 7'h1D;
    localparam logic [6:0]  ADDR_TEMP_LO     = 7'h20;
    localparam logic [6:0]  ADDR_TEMP_HI     = 7'h21;
    localparam logic [6:0]  ADDR_FILL_LO     = 7'h22;
    localparam logic [6:0]  ADDR_FILL_HI     = 7'h23;
    localparam logic [6:0]  ADDR_READOUT     = 7'h24;
    localparam logic [6:0]  ADDR_RATE_SETUP  = 7'h42;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned FLAG_FWM_BIT     = 6;
    localparam int unsigned FLAG_FFULL_BIT   = 5;
    localparam int unsigned FLAG_DRDY_BIT    = 4;
    localparam int unsigned CMD_RW_BIT       = 7;
    localparam int unsigned BWP_LSB          = 4;
    localparam int unsigned ODR_LSB          = 0;
    localparam logic [7:0]  RATE_SETUP_RESET = 8'h28;
    localparam logic [15:0] TEMP_RESET       = 16'h8000;
    localparam logic [15:0] TEMP_INVALID     = 16'h8000;
    localparam int unsigned FILL_W           = 11;
    localparam logic [10:0] FILL_RESET       = 11'h000;
    localparam int unsigned FRAME_LEN_W      = 6;
    localparam logic [7:0]  READOUT_EMPTY    = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  PMU_SUSPEND      = 2'h0;
    localparam logic [1:0]  PMU_NORMAL       = 2'h1;
    localparam logic [1:0]  PMU_FAST_START   = 2'h3;
    localparam logic        THERMAL_NORMAL   = 1'b1;
    localparam logic [3:0]  ODR_MIN_LEGAL    = 4'h6;
    localparam logic [3:0]  ODR_MAX_LEGAL    = 4'hD;
    localparam logic [1:0]  BWP_UNDEFINED    = 2'h3;
    localparam logic [7:0]  ERR_CODE_CONF    = 8'h01;
    localparam logic [7:0]  ERR_CODE_NONE    = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 100_000_000;
    localparam int unsigned TEMP_FAST_MS      = 10;
    localparam int unsigned TEMP_SLOW_MS      = 1280;
    localparam int unsigned ODR_REF_HZ        = 100;
    localparam int unsigned TEMP_FAST_CYCLES  = (CLK_HZ / 1000) * TEMP_FAST_MS;
    localparam int unsigned TEMP_SLOW_CYCLES  = (CLK_HZ / 1000) * TEMP_SLOW_MS;
    localparam int unsigned ODR_REF_CYCLES    = CLK_HZ / ODR_REF_HZ;

    typedef enum logic {SP_CMD, SP_DATA} gsf_spi_e;
    typedef enum logic [1:0] {TM_OFF, TM_FAST, TM_SLOW} gsf_temp_e;

endpackage

/* File: core/gsf_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for levels arriving from outside the clock domain.
module gsf_sync #(
    parameter int unsigned W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
)(
    input  wire logic         sys_clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage, never any logic.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            meta_q <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

/* File: verification/gsf_regs_chk.sv */
`timescale 1ns/1ps
// ----
// Port checker
// ----
module gsf_regs_chk
    import gsf_pkg::*;
#(
    parameter int TEMP_FAST_CYC = 200,
    parameter int ODR_REF_CYC   = 64
)(
    input wire logic       sys_clk_i,
    input wire logic       srst_i,
    input wire logic       spi_csn_i,
    input wire logic       spi_miso_oe_n_o,
    input wire logic [1:0] gyr_pmu_state_i,
    input wire logic       thermal_power_state_i,
    input wire logic       temp_meas_req_o,
    input wire logic [5:0] fifo_rd_offset_o,
    input wire logic [5:0] frame_rd_len_i,
    input wire logic       frame_pop_o,
    input wire logic [3:0] odr_code_o,
    input wire logic       sample_tick_o,
    input wire logic       conf_error_o,
    input wire logic [7:0] err_code_o
);
    int gap_q, run_q, tgap_q, trun_q, per_w;
    // Gaps since the last pulse, and how long the governing input held still.
    always_ff @(posedge sys_clk_i) begin
        gap_q  <= (srst_i || temp_meas_req_o) ? 0 : gap_q + 1;
        run_q  <= (srst_i || gyr_pmu_state_i != PMU_NORMAL) ? 0 : run_q + 1;
        tgap_q <= (srst_i || sample_tick_o) ? 0 : tgap_q + 1;
        trun_q <= (srst_i || odr_code_o != $past(odr_code_o)) ? 0 : trun_q + 1;
    end
    // Each code step above the slowest halves the tick period.
    assign per_w = ((ODR_REF_CYC * 4) >> (odr_code_o - 4'h6)) - 1;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    sequence both_off_s;
        gyr_pmu_state_i == PMU_SUSPEND && !thermal_power_state_i;
    endsequence
    sequence csn_quiet_s;
        spi_csn_i [*5];
    endsequence
    no_temp_a: assert property (both_off_s ##1 both_off_s |-> !temp_meas_req_o)
        else $error("temperature request while fully suspended");
    fast_gap_a: assert property (temp_meas_req_o && run_q > gap_q |-> gap_q == TEMP_FAST_CYC - 1)
        else $error("fast temperature period wrong");
    fast_due_a: assert property (run_q > gap_q && gap_q == TEMP_FAST_CYC - 1 |-> temp_meas_req_o)
        else $error("fast temperature request missing");
    tick_gap_a: assert property (sample_tick_o && trun_q > tgap_q |-> tgap_q == per_w)
        else $error("sample tick came early");
    tick_due_a: assert property (trun_q > tgap_q && tgap_q == per_w |-> sample_tick_o)
        else $error("sample tick missing");
    err_code_a: assert property (conf_error_o |-> err_code_o == ERR_CODE_CONF && $stable(odr_code_o))
        else $error("illegal setup changed rate or lacked code");
    odr_legal_a: assert property (odr_code_o >= ODR_MIN_LEGAL && odr_code_o <= ODR_MAX_LEGAL)
        else $error("illegal rate code applied");
    pop_end_a: assert property (frame_pop_o |-> $past(fifo_rd_offset_o) == frame_rd_len_i - 6'h01
        && fifo_rd_offset_o == 6'h00)
        else $error("frame advanced before its last byte");
    csn_idle_a: assert property (csn_quiet_s |-> spi_miso_oe_n_o && fifo_rd_offset_o == 6'h00)
        else $error("offset or drive kept after deselect");
    oe_drive_a: assert property (!spi_csn_i [*5] |-> !spi_miso_oe_n_o)
        else $error("data line not driven while selected");
endmodule
bind gsf_regs gsf_regs_chk #(
    .TEMP_FAST_CYC(TEMP_FAST_CYC),
    .ODR_REF_CYC  (ODR_REF_CYC)
) chk (.*);

/* File: verification/gsf_host.sv */
`timescale 1ns/1ps
// ----
// Serial host model
// ----
module gsf_host (
    output logic       spi_sck_o,
    output logic       spi_csn_o,
    output logic       spi_mosi_o,
    input  wire logic  spi_miso_i,
    output logic       rx_stb_o,
    output logic [7:0] rx_byte_o
);
    // Idle bus: clock low, device deselected.
    initial begin
        spi_sck_o  = 1'b0;
        spi_csn_o  = 1'b1;
        spi_mosi_o = 1'b0;
        rx_stb_o   = 1'b0;
        rx_byte_o  = 8'h00;
    end
    // One byte MSB first; data moves after the fall and is taken at the rise.
    task automatic xbyte(input logic [7:0] tx, input logic rd);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi_o = tx[i];
            #62.5 spi_sck_o = 1'b1;
            rx_byte_o[i] = spi_miso_i;
            #62.5 spi_sck_o = 1'b0;
        end
        rx_stb_o = rd;
        #1 rx_stb_o = 1'b0;
    endtask
    // Each call is one burst: the address byte goes out once, then n data bytes follow.
    task automatic frame(input logic rd, input logic [6:0] adr, input logic [7:0] wd, input int n);
        spi_csn_o = 1'b0;
        #100 xbyte({rd, adr}, 1'b0);
        repeat (n) xbyte(wd, rd);
        #100 spi_csn_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o;
        #100;
    endtask
endmodule

/* File: verification/test_gsf_regs.sv */
`timescale 1ns/1ps
// ----
// Bench top
// ----
module test_gsf_regs;
    import gsf_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        spi_sck_i, spi_csn_i, spi_mosi_i, spi_miso_o, spi_miso_oe_n_o, miso_w, rx_stb;
    logic        temp_meas_req_o, frame_pop_o, sample_tick_o, conf_error_o, thermal_power_state_i;
    logic        temp_done_i, fwm_event_i, ffull_event_i, drdy_event_i, frame_written_i;
    logic        fifo_reset_i, fifo_last_frame_i;
    logic [1:0]  gyr_pmu_state_i, bw_code_o, pops;
    logic [3:0]  odr_code_o;
    logic [5:0]  frame_wr_len_i, frame_rd_len_i, fifo_rd_offset_o;
    logic [7:0]  fifo_rd_byte_i, err_code_o, rx_byte;
    logic [15:0] temp_raw_i, lfsr_q;
    logic [7:0]  exp_q[$];
    logic [7:0]  wr_v[4] = '{8'h05, 8'h3D, 8'h0E, 8'hE8};
    int          error_cnt, compares;

    initial forever #5 sys_clk_i = ~sys_clk_i;

    gsf_regs #(.TEMP_FAST_CYC(200), .TEMP_SLOW_CYC(1000), .ODR_REF_CYC(64)) uut (.*);
    gsf_host host (
        .spi_sck_o (spi_sck_i),
        .spi_csn_o (spi_csn_i),
        .spi_mosi_o(spi_mosi_i),
        .spi_miso_i(miso_w),
        .rx_stb_o  (rx_stb),
        .rx_byte_o (rx_byte)
    );
    // No pull on the data line, so a released line wanders instead of holding.
    assign miso_w = spi_miso_oe_n_o ? ~spi_mosi_i : spi_miso_o;
    // Stand-ins for the measurement unit and the queue core.
    assign fifo_rd_byte_i = {pops, fifo_rd_offset_o};
    always @(negedge sys_clk_i) temp_done_i <= temp_meas_req_o;
    always @(posedge sys_clk_i) pops <= srst_i ? 2'h0 : pops + {1'b0, frame_pop_o};
    always @(posedge rx_stb) check(rx_byte, exp_q.pop_front());

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.frame(1'b1, a, 8'h00, 1);
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk_i) s = 1'b1;
        @(negedge sys_clk_i) s = 1'b0;
    endtask
    // Changes power state, waits, then reads the temperature word as one burst.
    task automatic temp_step(input logic [1:0] pm, input logic th, input int cyc, input logic ok);
        lfsr_q = lfsr(lfsr_q);
        @(negedge sys_clk_i);
        gyr_pmu_state_i = pm;
        thermal_power_state_i = th;
        temp_raw_i = lfsr_q;
        repeat (cyc) @(negedge sys_clk_i);
        exp_q.push_back(ok ? lfsr_q[7:0] : TEMP_INVALID[7:0]);
        exp_q.push_back(ok ? lfsr_q[15:8] : TEMP_INVALID[15:8]);
        host.frame(1'b1, ADDR_TEMP_LO, 8'h00, 2);
    endtask
    task automatic end_of_test();
        error_cnt += exp_q.size();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Main sequence.
    initial begin
        lfsr_q = 16'h1586;
        pops = 2'h0;
        {gyr_pmu_state_i, thermal_power_state_i, temp_raw_i, temp_done_i} = '0;
        {fwm_event_i, ffull_event_i, drdy_event_i, frame_written_i, fifo_reset_i, fifo_last_frame_i} = '0;
        frame_wr_len_i = 6'h06;
        frame_rd_len_i = 6'h06;
        repeat (20) @(negedge sys_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        rd(ADDR_RATE_SETUP, RATE_SETUP_RESET);
        rd(ADDR_TEMP_HI, TEMP_RESET[15:8]);
        rd(ADDR_FILL_LO, 8'h00);
        rd(7'h30, UNMAPPED_READ);
        $display("test reset_values done");
        for (int b = 4; b <= 6; b++) begin
            @(negedge sys_clk_i) {fwm_event_i, ffull_event_i, drdy_event_i} = 3'h1 << (b - 4);
            @(negedge sys_clk_i) {fwm_event_i, ffull_event_i, drdy_event_i} = 3'h0;
            rd(ADDR_INT_FLAGS, 8'h01 << b);
            host.frame(1'b0, ADDR_INT_FLAGS, 8'h01 << b, 1);
            rd(ADDR_INT_FLAGS, 8'h00);
        end
        $display("test flags done");
        temp_step(PMU_NORMAL, 1'b0, 450, 1'b1);
        temp_step(PMU_SUSPEND, 1'b0, 20, 1'b0);
        temp_step(PMU_FAST_START, 1'b0, 2100, 1'b1);
        temp_step(PMU_SUSPEND, 1'b1, 2100, 1'b1);
        temp_step(2'h2, 1'b1, 20, 1'b0);
        $display("test temperature done");
        pulse(frame_written_i);
        pulse(frame_written_i);
        exp_q.push_back(8'h0C);
        exp_q.push_back(8'h00);
        host.frame(1'b1, ADDR_FILL_LO, 8'h00, 2);
        for (int k = 0; k < 3; k++) begin
            @(negedge sys_clk_i) fifo_last_frame_i = (k == 2);
            for (int i = 0; i < (k == 0 ? 3 : 6); i++) exp_q.push_back({1'b0, k[1], i[5:0]});
            host.frame(1'b1, ADDR_READOUT, 8'h00, k == 0 ? 3 : 6);
            if (k == 1) rd(ADDR_FILL_LO, 8'h06);
        end
        rd(ADDR_FILL_LO, 8'h00);
        pulse(frame_written_i);
        pulse(fifo_reset_i);
        rd(ADDR_FILL_LO, FILL_RESET[7:0]);
        $display("test queue done");
        for (int c = 6; c <= 13; c++) begin
            host.frame(1'b0, ADDR_RATE_SETUP, {4'h2, c[3:0]}, 1);
            repeat (600) @(negedge sys_clk_i);
            check(odr_code_o, c[3:0]);
            check(err_code_o, ERR_CODE_NONE);
        end
        for (int k = 0; k < 4; k++) begin
            host.frame(1'b0, ADDR_RATE_SETUP, wr_v[k], 1);
            repeat (20) @(negedge sys_clk_i);
            check(odr_code_o, k < 3 ? 4'hD : 4'h8);
            check(err_code_o, k < 3 ? ERR_CODE_CONF : ERR_CODE_NONE);
        end
        check(bw_code_o, 2'h2);
        rd(ADDR_RATE_SETUP, 8'h28);
        $display("test rate done");
        end_of_test();
    end

    // Cuts a hang short well after the roughly 20k-cycle schedule should end.
    initial begin
        #600_000;
        error_cnt++;
        end_of_test();
    end
endmodule
